// *** rtl/mifd_consts.vh ***
// Summary of operation
// RULE1 - instruction is one 16-bit word, opcode plus operands
// RULE2 - d=0 result to working register, d=1 to file
// RULE3 - s=0 result to file and working register
// RULE4 - file operand is 8-bit address 00h-FFh
// RULE5 - peripheral operand is 5-bit address 00h-1Fh
// RULE6 - i=1 increments table pointer after execution
// RULE7 - t selects table latch low or high byte
// RULE8 - bit field picks bit of addressed file
// RULE9 - literal decoded as 8 or 13 bits
// RULE10 - unused fields must be encoded as zero
// RULE11 - true test or pc change adds one cycle
// RULE12 - table accesses take two cycles, second nop
// RULE13 - one instruction cycle is four clock periods
// RULE14 - global interrupt disable is status bit 4
// RULE15 - 16-bit pointer, latch split in two bytes
// RULE16 - alu keeps carry, nibble carry, zero, overflow
// RULE17 - four phases: decode, read, process, write
// RULE18 - hardware status updates happen only in phase 1
// RULE19 - reserved opcodes behave as undefined no-ops
// RULE20 - extra cycle made by forcing next decode nop
`ifndef MIFD_CONSTS_VH
`define MIFD_CONSTS_VH
// phases
`define MIFD_Q1 2'h0
`define MIFD_Q2 2'h1
`define MIFD_Q3 2'h2
`define MIFD_Q4 2'h3
// seven-bit opcodes, d or s in bit 8
`define MIFD_OP_ADDWF  7'h07
`define MIFD_OP_ANDWF  7'h05
`define MIFD_OP_IORWF  7'h04
`define MIFD_OP_SUBWF  7'h02
`define MIFD_OP_DECF   7'h03
`define MIFD_OP_INCF   7'h0A
`define MIFD_OP_COMF   7'h09
`define MIFD_OP_DECFSZ 7'h0B
`define MIFD_OP_INCFSZ 7'h0F
`define MIFD_OP_CLRF   7'h14
`define MIFD_OP_SETF   7'h15
// eight-bit opcodes
`define MIFD_OP_NOP    8'h00
`define MIFD_OP_MOVWF  8'h01
`define MIFD_OP_CPFSEQ 8'h31
// three-bit groups
`define MIFD_OP_MOVPF  3'h2
`define MIFD_OP_MOVFP  3'h3
// table group in the top nibble
`define MIFD_OP_TABLE  4'hA
// status bit positions
`define MIFD_GID_BIT   4
`define MIFD_FLAG_C    0
`define MIFD_FLAG_DC   1
`define MIFD_FLAG_Z    2
`define MIFD_FLAG_OV   3
// register port indices
`define MIFD_REG_STAT  3'h0
`define MIFD_REG_ALU   3'h1
`define MIFD_REG_WORKING_REGISTER  3'h2
`define MIFD_REG_TPL   3'h3
`define MIFD_REG_TPH   3'h4
`define MIFD_REG_TLL   3'h5
`define MIFD_REG_TLH   3'h6
`define MIFD_REG_IRL   3'h7
// reset values
`define MIFD_RST_GID   1'h1
`define MIFD_RST_FLAGS 4'h0
`define MIFD_RST_BYTE  8'h00
`define MIFD_RST_WORD  16'h0000
`endif

// *** rtl/mifd_decoder.v ***
`include "mifd_consts.vh"
`default_nettype none
module mifd_decoder (
   // clock and reset
   input  wire        clk,
   input  wire        nrst,
   // program memory
   input  wire [15:0] instr_word,
   output reg         fetch_strobe,
   // data memory
   input  wire [7:0]  file_rdata,
   output reg  [7:0]  file_addr,
   output reg         file_rd,
   output reg  [7:0]  file_wdata,
   output reg         file_we,
   // decoded operand fields
   output reg  [4:0]  periph_addr,
   output reg  [2:0]  bit_sel,
   output reg  [7:0]  lit8,
   output reg  [12:0] lit13,
   // sequencer
   input  wire        pc_change,
   output reg  [1:0]  phase,
   output reg         nop_cycle,
   output reg         skip_taken,
   output reg         reserved_op,
   output reg         unused_err,
   output reg         global_interrupt_disable,
   output reg  [15:0] table_pointer,
   // register port
   input  wire [2:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata
);

   localparam ALU_NONE = 4'h0;
   localparam ALU_ADD  = 4'h1;
   localparam ALU_SUB  = 4'h2;
   localparam ALU_INC  = 4'h3;
   localparam ALU_DEC  = 4'h4;
   localparam ALU_AND  = 4'h5;
   localparam ALU_IOR  = 4'h6;
   localparam ALU_COM  = 4'h7;
   localparam ALU_PASW = 4'h8;
   localparam ALU_PASF = 4'h9;
   localparam ALU_CLR  = 4'hA;
   localparam ALU_SET  = 4'hB;
   localparam ALU_CMP  = 4'hC;
   localparam ALU_TLRD = 4'hD;
   localparam ALU_TLWT = 4'hE;

   reg  [15:0] ir;
   reg  [7:0]  working_register;
   reg  [3:0]  alu_flags;
   reg  [3:0]  pend_flags;
   reg  [3:0]  pend_mask;
   reg  [7:0]  table_latch_low;
   reg  [7:0]  table_latch_high;
   reg  [7:0]  opnd;
   reg  [7:0]  result;
   reg         res_zero;
   reg         force_nop;
   // latched decode of the current word
   reg  [3:0]  alu_op;
   reg         dst_w;
   reg         dst_f;
   reg         is_skip;
   reg         is_tbl;
   reg         tbl_inc;
   reg         tbl_hi;
   reg  [7:0]  src_addr;
   reg  [7:0]  dst_addr;
   reg  [3:0]  upd_mask;

   // combinational decode
   reg  [3:0]  next_alu_op;
   reg         next_dst_w;
   reg         next_dst_f;
   reg         next_skip;
   reg         next_tbl;
   reg         next_rsvd;
   reg         next_unused;
   reg  [7:0]  next_src;
   reg  [7:0]  next_dst;
   reg  [3:0]  next_mask;

   wire [6:0]  op7 = ir[15:9];
   wire [7:0]  op8 = ir[15:8];
   wire        dbit = ir[8];

   always @* begin
      next_alu_op = ALU_NONE;
      next_dst_w  = 1'b0;
      next_dst_f  = 1'b0;
      next_skip   = 1'b0;
      next_tbl    = 1'b0;
      next_rsvd   = 1'b0;
      next_unused = 1'b0;
      next_src    = ir[7:0]; // RULE4
      next_dst    = ir[7:0];
      next_mask   = 4'h0;
      // RULE1
      if (ir[15:13] == `MIFD_OP_MOVPF) begin
         next_alu_op = ALU_PASF;
         next_src    = {3'h0, ir[12:8]}; // RULE5
         next_dst_f  = 1'b1;
         next_mask   = 4'h4;
      end else if (ir[15:13] == `MIFD_OP_MOVFP) begin
         next_alu_op = ALU_PASF;
         next_dst    = {3'h0, ir[12:8]}; // RULE5
         next_dst_f  = 1'b1;
      end else if (ir[15:12] == `MIFD_OP_TABLE) begin
         next_tbl    = 1'b1;
         next_alu_op = ir[10] ? ALU_TLWT : ALU_TLRD;
         next_dst_f  = ~ir[10];
      end else if (op8 == `MIFD_OP_NOP) begin
         next_unused = (ir[7:0] != 8'h00); // RULE10
      end else if (op8 == `MIFD_OP_MOVWF) begin
         next_alu_op = ALU_PASW;
         next_dst_f  = 1'b1;
      end else if (op8 == `MIFD_OP_CPFSEQ) begin
         next_alu_op = ALU_CMP;
         next_skip   = 1'b1;
      end else begin
         case (op7)
            `MIFD_OP_ADDWF:  next_alu_op = ALU_ADD;
            `MIFD_OP_SUBWF:  next_alu_op = ALU_SUB;
            `MIFD_OP_INCF:   next_alu_op = ALU_INC;
            `MIFD_OP_DECF:   next_alu_op = ALU_DEC;
            `MIFD_OP_ANDWF:  next_alu_op = ALU_AND;
            `MIFD_OP_IORWF:  next_alu_op = ALU_IOR;
            `MIFD_OP_COMF:   next_alu_op = ALU_COM;
            `MIFD_OP_INCFSZ: next_alu_op = ALU_INC;
            `MIFD_OP_DECFSZ: next_alu_op = ALU_DEC;
            `MIFD_OP_CLRF:   next_alu_op = ALU_CLR;
            `MIFD_OP_SETF:   next_alu_op = ALU_SET;
            default:         next_rsvd   = 1'b1; // RULE19
         endcase
         if (op7 == `MIFD_OP_CLRF || op7 == `MIFD_OP_SETF) begin
            next_dst_f = 1'b1; // RULE3
            next_dst_w = ~dbit;
         end else if (!next_rsvd) begin
            next_dst_f = dbit; // RULE2
            next_dst_w = ~dbit;
         end
         if (op7 == `MIFD_OP_INCFSZ || op7 == `MIFD_OP_DECFSZ) begin
            next_skip = 1'b1;
         end else if (next_alu_op == ALU_ADD || next_alu_op == ALU_SUB ||
                      next_alu_op == ALU_INC || next_alu_op == ALU_DEC) begin
            next_mask = 4'hF; // RULE16
         end else if (next_alu_op == ALU_AND || next_alu_op == ALU_IOR ||
                      next_alu_op == ALU_COM) begin
            next_mask = 4'h4;
         end
      end
   end

   // shared adder covers add, subtract, increment, decrement
   reg  [7:0]  add_y;
   reg         add_cin;
   wire [8:0]  sum9 = {1'b0, opnd} + {1'b0, add_y} + {8'h00, add_cin};
   wire [4:0]  nib  = {1'b0, opnd[3:0]} + {1'b0, add_y[3:0]} + {4'h0, add_cin};
   wire        sum_ov = (opnd[7] == add_y[7]) && (sum9[7] != opnd[7]);

   always @* begin
      add_y   = 8'h00;
      add_cin = 1'b0;
      case (alu_op)
         ALU_ADD: add_y = working_register;
         ALU_SUB: begin
            add_y   = ~working_register;
            add_cin = 1'b1;
         end
         ALU_INC: add_cin = 1'b1;
         ALU_DEC: add_y = 8'hFF;
         default: add_y = 8'h00;
      endcase
   end

   // phase counter and datapath
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phase        <= `MIFD_Q1;
         ir           <= `MIFD_RST_WORD;
         force_nop    <= 1'b1;
         nop_cycle    <= 1'b1;
         fetch_strobe <= 1'b0;
         file_addr    <= `MIFD_RST_BYTE;
         file_rd      <= 1'b0;
         file_wdata   <= `MIFD_RST_BYTE;
         file_we      <= 1'b0;
         periph_addr  <= 5'h00;
         bit_sel      <= 3'h0;
         lit8         <= `MIFD_RST_BYTE;
         lit13        <= 13'h0000;
         skip_taken   <= 1'b0;
         reserved_op  <= 1'b0;
         unused_err   <= 1'b0;
         alu_op       <= ALU_NONE;
         dst_w        <= 1'b0;
         dst_f        <= 1'b0;
         is_skip      <= 1'b0;
         is_tbl       <= 1'b0;
         tbl_inc      <= 1'b0;
         tbl_hi       <= 1'b0;
         src_addr     <= `MIFD_RST_BYTE;
         dst_addr     <= `MIFD_RST_BYTE;
         upd_mask     <= 4'h0;
         opnd         <= `MIFD_RST_BYTE;
         result       <= `MIFD_RST_BYTE;
         res_zero     <= 1'b0;
         pend_flags   <= `MIFD_RST_FLAGS;
         pend_mask    <= 4'h0;
      end else begin
         phase        <= phase + 2'h1; // RULE13
         fetch_strobe <= (phase == `MIFD_Q3);
         file_rd      <= 1'b0;
         file_we      <= 1'b0;
         case (phase) // RULE17
            `MIFD_Q1: begin
               // a forced nop keeps the fetched word but drops its effects
               nop_cycle   <= force_nop; // RULE20
               skip_taken  <= 1'b0;
               alu_op      <= force_nop ? ALU_NONE : next_alu_op;
               dst_w       <= ~force_nop & next_dst_w;
               dst_f       <= ~force_nop & next_dst_f;
               is_skip     <= ~force_nop & next_skip;
               is_tbl      <= ~force_nop & next_tbl;
               tbl_inc     <= ir[8]; // RULE6
               tbl_hi      <= ir[9]; // RULE7
               upd_mask    <= force_nop ? 4'h0 : next_mask;
               reserved_op <= ~force_nop & next_rsvd;
               unused_err  <= ~force_nop & next_unused;
               src_addr    <= next_src;
               dst_addr    <= next_dst;
               periph_addr <= ir[12:8];
               bit_sel     <= ir[10:8]; // RULE8
               lit8        <= ir[7:0]; // RULE9
               lit13       <= ir[12:0];
               pend_mask   <= 4'h0;
               file_addr   <= next_src;
               file_rd     <= ~force_nop;
            end
            `MIFD_Q2: begin
               opnd <= file_rdata;
            end
            `MIFD_Q3: begin
               case (alu_op)
                  ALU_ADD, ALU_SUB, ALU_INC, ALU_DEC: result <= sum9[7:0];
                  ALU_AND:  result <= opnd & working_register;
                  ALU_IOR:  result <= opnd | working_register;
                  ALU_COM:  result <= ~opnd;
                  ALU_PASW: result <= working_register;
                  ALU_CLR:  result <= 8'h00;
                  ALU_SET:  result <= 8'hFF;
                  ALU_TLRD: result <= tbl_hi ? table_latch_high : table_latch_low;
                  default:  result <= opnd;
               endcase
               if (alu_op == ALU_CMP)
                  res_zero <= (opnd == working_register);
               else
                  res_zero <= (sum9[7:0] == 8'h00);
               pend_flags[`MIFD_FLAG_C]  <= sum9[8];
               pend_flags[`MIFD_FLAG_DC] <= nib[4];
               pend_flags[`MIFD_FLAG_OV] <= sum_ov;
               pend_flags[`MIFD_FLAG_Z]  <= 1'b0;
               file_addr <= dst_addr;
            end
            default: begin
               file_wdata <= result;
               file_we    <= dst_f;
               skip_taken <= is_skip & res_zero;
               pend_flags[`MIFD_FLAG_Z] <= (result == 8'h00);
               pend_mask  <= upd_mask;
               // next word is sampled as the cycle closes
               ir         <= instr_word;
               force_nop  <= (is_skip & res_zero) | pc_change | is_tbl; // RULE11 RULE12
            end
         endcase
      end
   end

   // software-visible state; hardware updates win over a same-cycle write
   reg [7:0] rd_mux;
   always @* begin
      case (reg_addr)
         `MIFD_REG_STAT: rd_mux = {3'h0, global_interrupt_disable, 4'h0};
         `MIFD_REG_ALU:  rd_mux = {4'h0, alu_flags};
         `MIFD_REG_WORKING_REGISTER: rd_mux = working_register;
         `MIFD_REG_TPL:  rd_mux = table_pointer[7:0];
         `MIFD_REG_TPH:  rd_mux = table_pointer[15:8];
         `MIFD_REG_TLL:  rd_mux = table_latch_low;
         `MIFD_REG_TLH:  rd_mux = table_latch_high;
         default:        rd_mux = ir[7:0];
      endcase
   end

   wire q1 = (phase == `MIFD_Q1);
   wire q4 = (phase == `MIFD_Q4);

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata                <= `MIFD_RST_BYTE;
         global_interrupt_disable <= `MIFD_RST_GID;
         alu_flags                <= `MIFD_RST_FLAGS;
         working_register         <= `MIFD_RST_BYTE;
         table_pointer            <= `MIFD_RST_WORD;
         table_latch_low          <= `MIFD_RST_BYTE;
         table_latch_high         <= `MIFD_RST_BYTE;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
         if (reg_wr && reg_addr == `MIFD_REG_STAT)
            global_interrupt_disable <= reg_wdata[`MIFD_GID_BIT]; // RULE14
         // flags commit only at phase 1, so read-modify-write keeps them
         if (q1 && pend_mask != 4'h0)
            alu_flags <= (alu_flags & ~pend_mask) | (pend_flags & pend_mask); // RULE18
         else if (reg_wr && reg_addr == `MIFD_REG_ALU)
            alu_flags <= reg_wdata[3:0];
         if (q4 && dst_w)
            working_register <= result;
         else if (reg_wr && reg_addr == `MIFD_REG_WORKING_REGISTER)
            working_register <= reg_wdata;
         // pointer steps once the table instruction has executed
         if (q4 && is_tbl && tbl_inc)
            table_pointer <= table_pointer + 16'h0001; // RULE6 RULE15
         else if (reg_wr && reg_addr == `MIFD_REG_TPL)
            table_pointer[7:0] <= reg_wdata;
         else if (reg_wr && reg_addr == `MIFD_REG_TPH)
            table_pointer[15:8] <= reg_wdata;
         if (q4 && alu_op == ALU_TLWT && !tbl_hi)
            table_latch_low <= opnd; // RULE7
         else if (reg_wr && reg_addr == `MIFD_REG_TLL)
            table_latch_low <= reg_wdata;
         if (q4 && alu_op == ALU_TLWT && tbl_hi)
            table_latch_high <= opnd; // RULE7
         else if (reg_wr && reg_addr == `MIFD_REG_TLH)
            table_latch_high <= reg_wdata;
      end
   end

endmodule
`default_nettype wire

// *** tb/mifd_decoder_sva.sv ***
`include "mifd_consts.vh"
`default_nettype none
module mifd_decoder_sva (
   // clock and reset
   input wire logic        clk,
   input wire logic        nrst,
   // program memory side
   input wire logic [15:0] instr_word,
   input wire logic        fetch_strobe,
   input wire logic        pc_change,
   // data memory side
   input wire logic [7:0]  file_addr,
   input wire logic        file_rd,
   input wire logic        file_we,
   // decoded fields and sequencer
   input wire logic [4:0]  periph_addr,
   input wire logic [2:0]  bit_sel,
   input wire logic [7:0]  lit8,
   input wire logic [12:0] lit13,
   input wire logic [1:0]  phase,
   input wire logic        nop_cycle,
   input wire logic        skip_taken
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // fields of a forced nop are not promised, so they are left out
   wire q2_live = (phase == `MIFD_Q2) && !nop_cycle;

   AST_PHASE_RING: assert property (
      phase == `MIFD_Q1 |=> phase == `MIFD_Q2 ##1 phase == `MIFD_Q3 ##1 phase == `MIFD_Q4)
      else $error("phase did not advance through four steps");
   AST_FETCH_Q4: assert property (
      fetch_strobe == (phase == `MIFD_Q4))
      else $error("fetch strobe outside the last phase");
   AST_READ_Q2: assert property (
      file_rd |-> q2_live && file_addr == (($past(instr_word[15:13], 2) == `MIFD_OP_MOVPF) ?
                  {3'h0, $past(instr_word[12:8], 2)} : $past(instr_word[7:0], 2)))
      else $error("file read at wrong phase or address");
   AST_WRITE_Q1: assert property (
      file_we |-> phase == `MIFD_Q1 && $stable(file_addr))
      else $error("file write at wrong phase");
   AST_FIELDS: assert property (
      q2_live |-> periph_addr == $past(instr_word[12:8], 2)
                  && bit_sel == $past(instr_word[10:8], 2))
      else $error("peripheral or bit field wrong");
   AST_LITERALS: assert property (
      q2_live |-> lit13 == $past(instr_word[12:0], 2) && lit8 == $past(instr_word[7:0], 2))
      else $error("literal field wrong");
   AST_ADD_DEST: assert property (
      phase == `MIFD_Q4 && !nop_cycle && $past(instr_word[15:9], 4) == `MIFD_OP_ADDWF
      |=> file_we == $past(instr_word[8], 5))
      else $error("file write does not follow destination bit");
   AST_SKIP_NOP: assert property (
      skip_taken |=> nop_cycle && !file_rd)
      else $error("skipped word was not forced to no_operation");
   AST_PC_NOP: assert property (
      phase == `MIFD_Q4 && pc_change && !nop_cycle |=> ##1 nop_cycle [*3])
      else $error("word after a jump was not forced to no_operation");
   AST_TABLE_TWO: assert property (
      phase == `MIFD_Q4 && !nop_cycle && $past(instr_word[15:12], 4) == `MIFD_OP_TABLE
      |=> ##1 nop_cycle [*3])
      else $error("table access did not take a second cycle");

   COV_SKIP: cover property (skip_taken);
   COV_WRITE: cover property (file_we);
   COV_JUMP: cover property (phase == `MIFD_Q4 && pc_change);
endmodule
`default_nettype wire

// *** tb/mifd_decoder_tb_top.sv ***
`include "mifd_consts.vh"
`default_nettype none
module mifd_decoder_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        pc_change = 1'b0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [2:0]  reg_addr = 3'h0;
   logic [7:0]  reg_wdata = 8'h00;
   logic [7:0]  file_rdata = 8'h00;
   logic [7:0]  watch = 8'h00;
   wire  [15:0] instr_word;
   logic [1:0]  phase;
   logic [2:0]  bit_sel;
   logic [4:0]  periph_addr;
   logic [7:0]  file_addr, file_wdata, lit8, reg_rdata, hit_data;
   logic [12:0] lit13;
   logic [15:0] table_pointer;
   logic        fetch_strobe, file_rd, file_we, nop_cycle, skip_taken;
   logic        reserved_op, unused_err, global_interrupt_disable;
   logic        hit, sk_seen, ue_seen, ro_seen;
   int          n_fail, n_tests, cycles;

   mifd_progmem pm_u (.clk(clk), .fetch_strobe(fetch_strobe), .instr_word(instr_word));
   mifd_decoder dut_u (
      .clk(clk), .nrst(nrst), .instr_word(instr_word), .fetch_strobe(fetch_strobe),
      .file_rdata(file_rdata), .file_addr(file_addr), .file_rd(file_rd),
      .file_wdata(file_wdata), .file_we(file_we), .periph_addr(periph_addr),
      .bit_sel(bit_sel), .lit8(lit8), .lit13(lit13), .pc_change(pc_change), .phase(phase),
      .nop_cycle(nop_cycle), .skip_taken(skip_taken), .reserved_op(reserved_op),
      .unused_err(unused_err), .global_interrupt_disable(global_interrupt_disable),
      .table_pointer(table_pointer), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

   initial forever #5 clk = ~clk;

   // one watched file address per run keeps the monitor small
   always @(posedge clk) begin
      if (file_we && file_addr == watch) begin
         hit <= 1'b1;
         hit_data <= file_wdata;
      end
      if (skip_taken) sk_seen <= 1'b1;
      if (unused_err) ue_seen <= 1'b1;
      if (reserved_op) ro_seen <= 1'b1;
      cycles++;
      if (cycles > 3000) begin
         n_fail++;
         wrap_up();
      end
   end

   task automatic wrap_up;
      $display("tests=%0d failures=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // two words, then judge the write seen at the watched address
   task automatic run(input logic [15:0] w1, input logic [15:0] w2, input logic [7:0] rdv,
                      input logic [7:0] wa, input logic eh, input logic [7:0] ed);
      @(posedge clk);
      file_rdata <= rdv;
      watch <= wa;
      {hit, sk_seen, ue_seen, ro_seen} <= 4'h0;
      #1;
      pm_u.q.push_back(w1);
      pm_u.q.push_back(w2);
      repeat (20) @(posedge clk);
      chk(hit, eh);
      if (eh) chk(hit_data, ed);
   endtask

   task automatic t_reset;
      logic [7:0] d;
      reg_read(`MIFD_REG_STAT, d);
      chk(d & 8'h10, 8'h10);
      reg_read(`MIFD_REG_ALU, d);
      chk(d, 8'h00);
      chk(table_pointer, 16'h0000);
      reg_write(`MIFD_REG_IRL, 8'hA5);
      reg_read(`MIFD_REG_IRL, d);
      chk(d, 8'h00);
      reg_write(`MIFD_REG_STAT, 8'h00);
      #1 chk(global_interrupt_disable, 1'b0);
   endtask

   task automatic t_add;
      logic [7:0] d;
      reg_write(`MIFD_REG_WORKING_REGISTER, 8'h01);
      run(16'h0F20, 16'h0000, 8'h02, 8'h20, 1'b1, 8'h03);
      reg_write(`MIFD_REG_WORKING_REGISTER, 8'hFF);
      run(16'h0E20, 16'h0000, 8'h01, 8'h20, 1'b0, 8'h00);
      reg_read(`MIFD_REG_WORKING_REGISTER, d);
      chk(d, 8'h00);
      reg_read(`MIFD_REG_ALU, d);
      chk(d, 8'h07);
      run(16'h0FFF, 16'h0000, 8'h80, 8'hFF, 1'b1, 8'h80);
   endtask

   task automatic t_clear;
      logic [7:0] d;
      for (int s = 0; s < 2; s++) begin
         reg_write(`MIFD_REG_WORKING_REGISTER, 8'h5A);
         run({`MIFD_OP_CLRF, s[0], 8'h30}, 16'h0000, 8'h77, 8'h30, 1'b1, 8'h00);
         reg_read(`MIFD_REG_WORKING_REGISTER, d);
         chk(d, s ? 8'h5A : 8'h00);
      end
   endtask

   task automatic t_skip;
      reg_write(`MIFD_REG_WORKING_REGISTER, 8'h33);
      run({`MIFD_OP_CPFSEQ, 8'h40}, 16'h0F41, 8'h33, 8'h41, 1'b0, 8'h00);
      chk(sk_seen, 1'b1);
      run({`MIFD_OP_CPFSEQ, 8'h40}, 16'h0F41, 8'h34, 8'h41, 1'b1, 8'h67);
      chk(sk_seen, 1'b0);
   endtask

   task automatic t_pc;
      int n;
      @(posedge clk);
      watch <= 8'h51;
      hit <= 1'b0;
      #1;
      pm_u.q.push_back(16'h0F50);
      pm_u.q.push_back(16'h0F51);
      n = 0;
      while (!(file_rd && file_addr == 8'h50) && n < 20) begin
         @(posedge clk);
         #1 n++;
      end
      chk(n < 20, 1'b1);
      repeat (2) @(posedge clk);
      pc_change <= 1'b1;
      @(posedge clk);
      pc_change <= 1'b0;
      repeat (12) @(posedge clk);
      chk(hit, 1'b0);
   endtask

   task automatic t_table;
      logic [7:0] d;
      reg_write(`MIFD_REG_TPL, 8'hFF);
      reg_write(`MIFD_REG_TPH, 8'h00);
      reg_write(`MIFD_REG_TLL, 8'h5A);
      reg_write(`MIFD_REG_TLH, 8'hA5);
      run(16'hA130, 16'h0000, 8'h00, 8'h30, 1'b1, 8'h5A);
      chk(table_pointer, 16'h0100);
      run(16'hA230, 16'h0F31, 8'h00, 8'h31, 1'b0, 8'h00);
      run(16'hA230, 16'h0000, 8'h00, 8'h30, 1'b1, 8'hA5);
      chk(table_pointer, 16'h0100);
      // file to latch direction: high byte loads, no file write
      run(16'hA640, 16'h0000, 8'hC3, 8'h40, 1'b0, 8'h00);
      reg_read(`MIFD_REG_TLH, d);
      chk(d, 8'hC3);
      reg_read(`MIFD_REG_TLL, d);
      chk(d, 8'h5A);
      chk(table_pointer, 16'h0100);
   endtask

   task automatic t_odd;
      run(16'h7F20, 16'h5F21, 8'h9C, 8'h21, 1'b1, 8'h9C);
      run(16'hFFFF, 16'h0001, 8'h00, 8'hFF, 1'b0, 8'h00);
      chk(ro_seen, 1'b1);
      chk(ue_seen, 1'b1);
   endtask

   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_add();
      t_clear();
      t_skip();
      t_pc();
      t_table();
      t_odd();
      wrap_up();
   end
endmodule

bind mifd_decoder mifd_decoder_sva chk_u (
   .clk(clk), .nrst(nrst), .instr_word(instr_word), .fetch_strobe(fetch_strobe),
   .pc_change(pc_change), .file_addr(file_addr), .file_rd(file_rd), .file_we(file_we),
   .periph_addr(periph_addr), .bit_sel(bit_sel), .lit8(lit8), .lit13(lit13),
   .phase(phase), .nop_cycle(nop_cycle), .skip_taken(skip_taken));
`default_nettype wire

// *** tb/mifd_progmem.sv ***
`default_nettype none
module mifd_progmem (
   // clock
   input  wire logic        clk,
   // fetch port
   input  wire logic        fetch_strobe,
   output wire logic [15:0] instr_word
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] q[$];
   logic [15:0] head;
   logic [15:0] last = 16'h0000;
   logic [15:0] word = 16'hFFFF;
   // words change mid-cycle, clear of the edge that samples them
   assign instr_word = word;
   always @(negedge clk) begin
      if (fetch_strobe) begin
         // an empty store answers no_operation words
         head = (q.size() != 0) ? q.pop_front() : 16'h0000;
         word <= head;
         last <= head;
      end else begin
         // bus is not held between fetches, so stale words cannot pass
         word <= ~last;
      end
   end
endmodule
`default_nettype wire
